// ===== plwdt_consts.vh
// constants for the program loop watchdog
`ifndef PLWDT_CONSTS_VH
`define PLWDT_CONSTS_VH
`define PLWDT_ADDR_MODE      16'hFF48
`define PLWDT_ADDR_KEY       16'hFF49
`define PLWDT_MODE_RESET     8'h67
`define PLWDT_KEY_RESET      8'h9A
`define PLWDT_KEY_RESTART    8'hAC
`define PLWDT_MODE_FIXED_HI  3'h3
`define PLWDT_BIT_CLK_HI     4
`define PLWDT_BIT_CLK_LO     3
`define PLWDT_LOW_BASE_EXP   11
`define PLWDT_SYS_BASE_EXP   13
`define PLWDT_RESUME_NS      34000
`define PLWDT_CLK_PERIOD_NS  4
`define PLWDT_RESUME_CYCLES  (`PLWDT_RESUME_NS / `PLWDT_CLK_PERIOD_NS)
`define PLWDT_CNT_W          21
`endif

// ===== plwdt_sync.v
// two-flop synchroniser used for reset release
module plwdt_sync (
    // clock and async reset
    input  wire mclk_i,
    input  wire rst_n_i,
    // synchronised level
    output wire q_o
);
    reg s1_r;
    reg s2_r;

    // release only after two edges
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else begin
            s1_r <= 1'b1;
            s2_r <= s1_r;
        end
    end

    assign q_o = s2_r;
endmodule

// ===== plwdt_resume.v
// settle-then-resume timer after stop mode on the system clock
`include "plwdt_consts.vh"
module plwdt_resume #(
    parameter CYCLES = `PLWDT_RESUME_CYCLES
) (
    // clock and reset
    input  wire mclk_i,
    input  wire rst_n_i,
    // control
    input  wire start_i,
    input  wire settle_i,
    // status
    output wire busy_o
);
    reg [15:0] cnt_r;

    // counts down the resume delay, then waits for oscillator settle
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= 16'h0000;
        end else if (start_i) begin
            cnt_r <= CYCLES[15:0];
        end else if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
        end
    end

    assign busy_o = (cnt_r != 16'h0000) || !settle_i;
endmodule

// ===== plwdt_top.v
// program loop watchdog: mode and restart-key registers, counter, reset request
// Notes on behaviour
// - mode register resets to 67H; top three bits read 0,1,1.
// - clock select 00 low-speed, 01 system clock, 1x stops.
// - interval n overflows after 2^(11+n) low or 2^(13+n) system ticks.
// - after reset count at once on low-speed clock, longest interval.
// - second mode write causes internal reset unless stopped exemption applies.
// - any mode register write clears the counter.
// - writing ACH to restart key clears counter and continues counting.
// - any other restart key value causes internal reset.
// - single-bit access to restart key causes internal reset.
// - restart key resets to and always reads 9AH.
// - first write stopping watchdog exempts later misuse from reset.
// - fixed option ignores clock select, always low-speed, never stops.
// - fixed option keeps counting in stop and resets on overflow.
// - stoppable option freezes count in halt and stop, keeps value.
// - system clock after stop waits 34 us plus settling before resuming.
// - reaching the selected interval raises internal reset.
// - watchdog reset flags bit 4 of the reset cause register.
`include "plwdt_consts.vh"
module plwdt_top #(
    parameter CNT_W         = `PLWDT_CNT_W,
    parameter RESUME_CYCLES = `PLWDT_RESUME_CYCLES
) (
    // clock and reset
    input  wire        mclk_i,
    input  wire        rst_n_i,
    // cpu register port
    input  wire [15:0] addr_i,
    input  wire        wr_i,
    input  wire        rd_i,
    input  wire        bit_op_i,
    input  wire [7:0]  wdata_i,
    output wire [7:0]  rdata_o,
    // count sources, as one-cycle tick enables
    input  wire        low_speed_osc_clock_i,
    input  wire        main_system_clock_i,
    // power modes and option
    input  wire        halt_i,
    input  wire        stop_i,
    input  wire        osc_settled_i,
    input  wire        opt_fixed_osc_i,
    // reset request and cause flag
    output wire        wdt_reset_o,
    output wire        loop_reset_flag_o
);
    wire rst_s_n;

    reg [4:0]       mode_r;
    reg             mode_written_r;
    reg             exempt_r;
    reg             fixed_r;
    reg [CNT_W-1:0] cnt_r;
    reg [CNT_W-1:0] cnt_nxt;
    reg             rst_req_r;
    reg             stop_d_r;
    reg [7:0]       rdata_r;

    wire mode_wr;
    wire key_wr;
    wire clk_hi;
    wire clk_lo;
    wire use_sys;
    wire stopped;
    wire tick;
    wire paused;
    wire misuse;
    wire overflow;
    wire resume_busy;
    wire stop_exit;
    wire cnt_clr;

    // full reset byte kept so the stored field is cut on purpose
    localparam [7:0] MODE_RST = `PLWDT_MODE_RESET;

    // overflow count for an interval and base exponent
    function [CNT_W-1:0] plwdt_limit;
        input [2:0] n;
        input       sys;
        reg   [4:0] e;
        begin
            e = {2'b00, n} + (sys ? 5'd13 : 5'd11);
            plwdt_limit = {{(CNT_W-1){1'b0}}, 1'b1} << e;
        end
    endfunction

    plwdt_sync u_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .q_o     (rst_s_n)
    );

    // system-clock resume delay after stop
    assign stop_exit = stop_d_r && !stop_i;

    plwdt_resume #(
        .CYCLES (RESUME_CYCLES)
    ) u_resume (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_s_n),
        .start_i  (stop_exit && use_sys),
        .settle_i (osc_settled_i),
        .busy_o   (resume_busy)
    );

    assign mode_wr = wr_i && (addr_i == `PLWDT_ADDR_MODE);
    assign key_wr  = wr_i && (addr_i == `PLWDT_ADDR_KEY);

    // fixed option forces low-speed and running
    assign clk_hi  = fixed_r ? 1'b0 : mode_r[`PLWDT_BIT_CLK_HI];
    assign clk_lo  = fixed_r ? 1'b0 : mode_r[`PLWDT_BIT_CLK_LO];
    assign stopped = clk_hi;
    assign use_sys = !clk_hi && clk_lo;

    // fixed option never pauses; stoppable pauses in halt, stop, and resume
    assign paused = !fixed_r && (halt_i || stop_i || (use_sys && resume_busy));
    assign tick   = !stopped && !paused &&
                    (use_sys ? main_system_clock_i : low_speed_osc_clock_i);

    // misuse: second mode write, bad key, bit access to key
    assign misuse = !exempt_r && ((mode_wr && mode_written_r) ||
                    (key_wr && (bit_op_i || wdata_i != `PLWDT_KEY_RESTART)));

    // a restart in the overflow cycle wins, so a timely restart never resets
    assign cnt_clr  = mode_wr || (key_wr && wdata_i == `PLWDT_KEY_RESTART && !bit_op_i);
    assign overflow = tick && !cnt_clr &&
                      (cnt_r + {{(CNT_W-1){1'b0}}, 1'b1} >= plwdt_limit(mode_r[2:0], use_sys));

    // mode register and one-shot guard; option caught after release
    always @(posedge mclk_i or negedge rst_s_n) begin
        if (!rst_s_n) begin
            mode_r         <= MODE_RST[4:0];
            mode_written_r <= 1'b0;
            exempt_r       <= 1'b0;
            fixed_r        <= 1'b1;
        end else begin
            if (!mode_written_r && !mode_wr) begin
                fixed_r <= opt_fixed_osc_i;
            end
            if (mode_wr && !mode_written_r) begin
                mode_r         <= wdata_i[4:0];
                mode_written_r <= 1'b1;
                exempt_r       <= !fixed_r && wdata_i[`PLWDT_BIT_CLK_HI];
            end
        end
    end

    // counter: cleared by mode write or good key, else counts ticks
    always @* begin
        cnt_nxt = cnt_r;
        if (mode_wr) begin
            cnt_nxt = {CNT_W{1'b0}};
        end else if (key_wr && wdata_i == `PLWDT_KEY_RESTART && !bit_op_i) begin
            cnt_nxt = {CNT_W{1'b0}};
        end else if (tick) begin
            cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // reset request held until the external reset controller resets us
    always @(posedge mclk_i or negedge rst_s_n) begin
        if (!rst_s_n) begin
            cnt_r     <= {CNT_W{1'b0}};
            rst_req_r <= 1'b0;
            stop_d_r  <= 1'b0;
            rdata_r   <= 8'h00;
        end else begin
            cnt_r    <= cnt_nxt;
            stop_d_r <= stop_i;
            if (misuse || overflow) begin
                rst_req_r <= 1'b1;
            end
            // key register always reads its reset value
            if (rd_i && addr_i == `PLWDT_ADDR_MODE) begin
                rdata_r <= {`PLWDT_MODE_FIXED_HI, mode_r};
            end else if (rd_i && addr_i == `PLWDT_ADDR_KEY) begin
                rdata_r <= `PLWDT_KEY_RESET;
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    assign rdata_o           = rdata_r;
    assign wdt_reset_o       = rst_req_r;
    assign loop_reset_flag_o = rst_req_r;
endmodule

// ===== plwdt_sva.sv
// port assertions for the program loop watchdog
module plwdt_sva #(
    parameter CNT_W         = 21,
    parameter RESUME_CYCLES = 8500
) (
    input wire        mclk_i,
    input wire        rst_n_i,
    input wire [15:0] addr_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire        bit_op_i,
    input wire [7:0]  wdata_i,
    input wire [7:0]  rdata_o,
    input wire        opt_fixed_osc_i,
    input wire        wdt_reset_o,
    input wire        loop_reset_flag_o
);
    reg  seen_r;
    reg  exempt_r;
    wire kw = wr_i && addr_i == 16'hFF49;
    wire mw = wr_i && addr_i == 16'hFF48;
    // first mode write decides whether later misuse is forgiven
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_r   <= 1'b0;
            exempt_r <= 1'b0;
        end else if (mw && !seen_r) begin
            seen_r   <= 1'b1;
            exempt_r <= wdata_i[4] && !opt_fixed_osc_i;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    AST_MODE_RESET: assert property (rd_i && addr_i == 16'hFF48 && !seen_r |=> rdata_o == 8'h67)
        else $error("mode reset value wrong");
    AST_MODE_TOP: assert property (rd_i && addr_i == 16'hFF48 |=> rdata_o[7:5] == 3'h3)
        else $error("mode top bits wrong");
    AST_KEY_READ: assert property (rd_i && addr_i == 16'hFF49 |=> rdata_o == 8'h9A)
        else $error("key read wrong");
    AST_BAD_KEY: assert property (kw && !bit_op_i && wdata_i != 8'hAC && !exempt_r |=> wdt_reset_o)
        else $error("bad key without reset");
    AST_BIT_KEY: assert property (kw && bit_op_i && !exempt_r |=> wdt_reset_o)
        else $error("bit access without reset");
    AST_SECOND_MODE: assert property (mw && seen_r && !exempt_r |=> wdt_reset_o)
        else $error("second mode write without reset");
    AST_EXEMPT: assert property (exempt_r |-> !$rose(wdt_reset_o))
        else $error("reset while stopped");
    AST_GOOD_KEY: assert property (kw && !bit_op_i && wdata_i == 8'hAC && !wdt_reset_o |=> !wdt_reset_o)
        else $error("good key caused reset");
    AST_STICKY: assert property (wdt_reset_o |=> wdt_reset_o)
        else $error("reset request dropped");
    AST_FLAG: assert property (loop_reset_flag_o == wdt_reset_o)
        else $error("cause flag differs");
endmodule
bind plwdt_top plwdt_sva #(.CNT_W(CNT_W), .RESUME_CYCLES(RESUME_CYCLES)) u_sva (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .bit_op_i(bit_op_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .opt_fixed_osc_i(opt_fixed_osc_i), .wdt_reset_o(wdt_reset_o),
    .loop_reset_flag_o(loop_reset_flag_o));

// ===== tb_program_loop_watchdog.sv
// self-checking bench for the program loop watchdog
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("ERROR %0t got %h", $time, a); end end
module tb_program_loop_watchdog;
    timeunit 1ns;
    timeprecision 1ns;
    reg        mclk_i, rst_n_i, wr_i, rd_i, bit_op_i, tick, halt_i, stop_i, opt_fixed, settled;
    reg [15:0] addr_i;
    reg [7:0]  wdata_i;
    reg [31:0] seed;
    wire [7:0] rdata_o;
    wire       wdt_reset_o, flag;
    int        err_count, comparisons, i;
    plwdt_top #(.CNT_W(21), .RESUME_CYCLES(10)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wr_i(wr_i), .rd_i(rd_i), .bit_op_i(bit_op_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .low_speed_osc_clock_i(tick), .main_system_clock_i(tick), .halt_i(halt_i), .stop_i(stop_i),
        .osc_settled_i(settled), .opt_fixed_osc_i(opt_fixed), .wdt_reset_o(wdt_reset_o), .loop_reset_flag_o(flag));
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // overflow length in ticks for interval n on either source
    function automatic int ovf(input [2:0] n, input s);
        ovf = 1 << (s ? 13 + n : 11 + n);
    endfunction
    task wr(input [15:0] a, input [7:0] d, input b);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        bit_op_i <= b;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        bit_op_i <= 1'b0;
    endtask
    task rd(input [15:0] a, input [7:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        `CHK(rdata_o, e)
    endtask
    task chk_rst(input int n, input e);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
        `CHK(wdt_reset_o, e)
        `CHK(flag, e)
    endtask
    // option is set while reset is low, as it is sampled at release
    task do_reset(input f);
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        opt_fixed <= f;
        stop_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
    endtask
    task give_verdict;
        if (err_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    // hang guard, well beyond the longest overflow wait
    initial begin
        #200000;
        err_count++;
        give_verdict;
    end
    initial begin
        {rst_n_i, wr_i, rd_i, bit_op_i, halt_i, stop_i, opt_fixed} = 7'h00;
        tick = 1'b1;
        settled = 1'b1;
        addr_i = 16'h0000;
        wdata_i = 8'h00;
        seed = 32'hE3BA5DF9;
        do_reset(1'b0);
        chk_rst(0, 1'b0);
        rd(16'hFF48, 8'h67);
        rd(16'hFF49, 8'h9A);
        wr(16'hFF49, 8'hAC, 1'b0);
        chk_rst(2, 1'b0);
        rd(16'hFF49, 8'h9A);
        wr(16'hFF48, 8'h67, 1'b0);
        wr(16'hFF48, 8'h60, 1'b0);
        chk_rst(2, 1'b1);
        for (i = 0; i < 3; i++) begin
            do_reset(1'b0);
            seed = lfsr(seed);
            wr(16'hFF49, (seed[7:0] == 8'hAC) ? 8'h53 : seed[7:0], 1'b0);
            chk_rst(2, 1'b1);
        end
        do_reset(1'b0);
        wr(16'hFF49, 8'hAC, 1'b1);
        chk_rst(2, 1'b1);
        do_reset(1'b0);
        wr(16'hFF48, 8'h70, 1'b0);
        wr(16'hFF48, 8'h60, 1'b0);
        wr(16'hFF49, 8'h11, 1'b0);
        wr(16'hFF49, 8'hAC, 1'b1);
        chk_rst(2, 1'b0);
        rd(16'hFF48, 8'h70);
        // default count runs first, so a missed clear would overflow early
        do_reset(1'b0);
        chk_rst(1500, 1'b0);
        wr(16'hFF48, 8'h60, 1'b0);
        chk_rst(1000, 1'b0);
        wr(16'hFF49, 8'hAC, 1'b0);
        chk_rst(1000, 1'b0);
        @(posedge mclk_i);
        halt_i <= 1'b1;
        chk_rst(3000, 1'b0);
        @(posedge mclk_i);
        halt_i <= 1'b0;
        chk_rst(ovf(3'h0, 1'b0) - 1020, 1'b0);
        chk_rst(30, 1'b1);
        do_reset(1'b0);
        wr(16'hFF48, 8'h68, 1'b0);
        chk_rst(ovf(3'h0, 1'b1) - 20, 1'b0);
        chk_rst(30, 1'b1);
        // stop on system clock with slow settle: count held, then resumes
        do_reset(1'b0);
        wr(16'hFF48, 8'h68, 1'b0);
        chk_rst(4000, 1'b0);
        @(posedge mclk_i);
        stop_i <= 1'b1;
        settled <= 1'b0;
        chk_rst(200, 1'b0);
        @(posedge mclk_i);
        stop_i <= 1'b0;
        chk_rst(50, 1'b0);
        @(posedge mclk_i);
        settled <= 1'b1;
        chk_rst(ovf(3'h0, 1'b1) - 4001 - 20, 1'b0);
        chk_rst(30, 1'b1);
        do_reset(1'b1);
        @(posedge mclk_i);
        stop_i <= 1'b1;
        wr(16'hFF48, 8'h70, 1'b0);
        chk_rst(ovf(3'h0, 1'b0) - 20, 1'b0);
        chk_rst(30, 1'b1);
        give_verdict;
    end
endmodule
